/* File: hdl/video_frontend_control_regs.v */
// control and status register bank of the video decoder front end
// What this block does
// - auto standard recognition follows enable register bit 0, cleared at reset
// - recognition status bit 0 set on vertical standard error while enable register bit 0 is set
// - any routing write stores value and reinitializes the current standard
// - routing bits 4:3 pick tilt compensation off, 6 dB, 12 dB
// - routing bits 6:5 pick chroma bandwidth narrow, normal, broad, wide
// - routing bit 7 chooses adaptive or fixed notch for sequential colour
// - routing bit 8 enables luma lowpass filter
// - routing bits 10:9 pick loop speed unchanged, terrestrial, recorder
// - software writes routing bit 11 zero; device sets it when done
// - start position applies only on next standard select write
// - luma delay from bits 11:6, applied on standard write; low bits zero
// - comb bits 1:0 select notch shape flat to maximum peaking
// - comb bits 3:2 set diagonal dot reduction, 00 min to 11 max
// - comb bits 5:4 set horizontal difference gain, 00 min to 11 max
// - comb bits 7:6 set vertical difference gain inverted, 00 max
// - comb bits 11:8 vertical peaking gain, zero disables it
// - test bit 2 enables DC rejection; bits 1:0 kept zero
// - test bit 3 enables coring; bits 11:4 kept zero
//
// Our own choice: the Avalon-MM register port.
`include "video_frontend_defines.vh"
module video_frontend_control_regs (
  input  wire        clk_sys,
  input  wire        reset_n,
  input  wire [10:0] avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  output reg  [1:0]  avs_response,
  input  wire        vertical_error,
  output reg         auto_standard_on,
  output reg  [2:0]  standard_code,
  output reg         standard_reinit,
  output reg  [11:0] start_position,
  output reg  [5:0]  luma_delay,
  output reg  [1:0]  luma_input_select,
  output reg         chroma_input_select,
  output reg  [1:0]  tilt_compensation,
  output reg  [1:0]  chroma_bandwidth,
  output reg         notch_fixed,
  output reg         luma_lowpass_on,
  output reg  [1:0]  loop_speed,
  output reg  [1:0]  notch_shape,
  output reg  [1:0]  dot_reduction,
  output reg  [1:0]  horiz_diff_gain,
  output reg  [1:0]  vert_diff_gain,
  output reg  [3:0]  vert_peak_gain,
  output reg         dc_reject_on,
  output reg         coring_on,
  output reg         irq
);

  reg  [11:0] std_select;
  reg  [11:0] routing;
  reg  [11:0] start_pending;
  reg  [11:0] delay_pending;
  reg  [11:0] comb_filter_control;
  reg  [11:0] comb_test;
  reg  [11:0] auto_enable;
  reg  [11:0] auto_state;
  reg  [1:0]  irq_status;
  reg  [1:0]  irq_mask;
  reg  [3:0]  reinit_count;
  reg         verr_meta;
  reg         verr_sync;
  reg         verr_prev;
  reg         access_done;
  reg  [11:0] read_word;
  reg         read_hit;
  wire [8:0]  index;
  wire        request;
  wire        wr_go;
  wire        verr_rise;
  wire        done_event;
  wire [11:0] mask_word;
  wire        wr_std;
  wire        wr_route;
  reg         next_auto_on;
  reg  [1:0]  next_luma_sel;
  reg         next_chroma_sel;
  reg  [1:0]  next_tilt;
  reg  [1:0]  next_bandwidth;
  reg         next_notch_fixed;
  reg         next_lowpass;
  reg  [1:0]  next_speed;
  reg  [1:0]  next_notch_shape;
  reg  [1:0]  next_dot;
  reg  [1:0]  next_hdg;
  reg  [1:0]  next_vdg;
  reg  [3:0]  next_vpk;
  reg         next_dcr;
  reg         next_coring;
  localparam [11:0] STD_RESET  = `RST_STD_SELECT;
  localparam [11:0] MASK_RESET = `RST_IRQ_MASK;

  // byte lanes: only lanes 0 and 1 carry the twelve bits
  function [11:0] merge;
    input [11:0] old;
    input [31:0] data;
    input [3:0]  be;
    input [11:0] wmask;
    reg   [11:0] lanes;
    begin
      lanes = {{4{be[1]}}, {8{be[0]}}} & wmask;
      merge = (old & ~lanes) | (data[11:0] & lanes);
    end
  endfunction

  function hit;
    input [8:0] idx;
    input [8:0] target;
    begin
      hit = (idx == target);
    end
  endfunction

  // reserved code 11 falls back to 00 so the core never sees it
  function [1:0] legal_code;
    input [1:0] code;
    begin
      legal_code = (code == 2'h3) ? 2'h0 : code;
    end
  endfunction

  assign index      = avs_address[10:2];
  assign request    = (avs_read | avs_write) & ~access_done;
  // writes land on the edge that sees waitrequest low, as the master expects
  assign wr_go      = avs_write & access_done;
  assign wr_std     = wr_go & hit(index, `IDX_STD_SELECT);
  assign wr_route   = wr_go & hit(index, `IDX_ROUTING);
  assign mask_word  = merge({10'h000, irq_mask}, avs_writedata, avs_byteenable, 12'h003);
  assign verr_rise  = verr_sync & ~verr_prev;
  assign done_event = (reinit_count == 4'h1);

  // one wait cycle: every access answered on the second edge
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      access_done <= 1'b0;
    end else begin
      access_done <= request;
    end
  end

  // idle high so no access can be mistaken as answered
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~request;
    end
  end

  always @* begin
    read_hit  = 1'b1;
    read_word = 12'h000;
    case (index)
      `IDX_STD_SELECT:   read_word = std_select;
      `IDX_ROUTING:      read_word = routing;
      `IDX_START_POS:    read_word = start_pending;
      `IDX_DELAY:        read_word = delay_pending;
      `IDX_COMB_CTRL:    read_word = comb_filter_control;
      `IDX_COMB_TEST:    read_word = comb_test;
      `IDX_AUTO_ENABLE:  read_word = auto_enable;
      `IDX_AUTO_STATE:   read_word = auto_state;
      `IDX_IRQ_STATUS:   read_word = {10'h000, irq_status};
      `IDX_IRQ_MASK:     read_word = {10'h000, irq_mask};
      `IDX_EVENT_INPUTS: read_word = {11'h000, verr_sync};
      default:           read_hit  = 1'b0;
    endcase
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      avs_readdata <= 32'h00000000;
    end else if (request) begin
      avs_readdata <= avs_read ? {20'h00000, read_word} : 32'h00000000;
    end
  end

  // unmapped addresses answer slave error, reads as zero
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      avs_response <= 2'h0;
    end else if (request) begin
      avs_response <= read_hit ? 2'h0 : 2'h2;
    end
  end

  // vertical error arrives from the decoder core, another domain
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      verr_meta <= 1'b0;
      verr_sync <= 1'b0;
      verr_prev <= 1'b0;
    end else begin
      verr_meta <= vertical_error;
      verr_sync <= verr_meta;
      verr_prev <= verr_sync;
    end
  end

  // one process per register keeps each write decode local
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      std_select <= `RST_STD_SELECT;
    end else if (wr_std) begin
      std_select <= merge(std_select, avs_writedata, avs_byteenable, 12'h007);
    end
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      start_pending <= `RST_START_POS;
    end else if (wr_go && hit(index, `IDX_START_POS)) begin
      start_pending <= merge(start_pending, avs_writedata, avs_byteenable, 12'hfff);
    end
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      delay_pending <= `RST_DELAY;
    end else if (wr_go && hit(index, `IDX_DELAY)) begin
      delay_pending <= merge(delay_pending, avs_writedata, avs_byteenable, `DELAY_WR_MASK);
    end
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      comb_filter_control <= `RST_COMB_CTRL;
    end else if (wr_go && hit(index, `IDX_COMB_CTRL)) begin
      comb_filter_control <= merge(comb_filter_control, avs_writedata, avs_byteenable, 12'hfff);
    end
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      comb_test <= `RST_COMB_TEST;
    end else if (wr_go && hit(index, `IDX_COMB_TEST)) begin
      comb_test <= merge(comb_test, avs_writedata, avs_byteenable, `TEST_WR_MASK);
    end
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      auto_enable <= `RST_AUTO_ENABLE;
    end else if (wr_go && hit(index, `IDX_AUTO_ENABLE)) begin
      auto_enable <= merge(auto_enable, avs_writedata, avs_byteenable, 12'h001);
    end
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      irq_mask <= MASK_RESET[1:0];
    end else if (wr_go && hit(index, `IDX_IRQ_MASK)) begin
      irq_mask <= mask_word[1:0];
    end
  end

  // routing write stores value, clears done bit, starts reinit countdown
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      routing      <= `RST_ROUTING;
      reinit_count <= 4'h0;
    end else if (wr_route) begin
      routing      <= merge(routing, avs_writedata, avs_byteenable, `ROUTE_WR_MASK)
                      & `ROUTE_WR_MASK;
      reinit_count <= `REINIT_CYCLES;
    end else if (reinit_count != 4'h0) begin
      reinit_count <= reinit_count - 4'h1;
      if (done_event)
        routing[`ROUTE_DONE_BIT] <= 1'b1;
    end
  end

  // status bit sticky while recognition runs
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      auto_state <= 12'h000;
    end else if (auto_enable[0] && verr_sync) begin
      auto_state[0] <= 1'b1;
    end else if (!auto_enable[0]) begin
      auto_state[0] <= 1'b0;
    end
  end

  // write one to clear; a new event in the same cycle wins
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      irq_status <= 2'h0;
    end else begin
      irq_status <= (irq_status & ~((wr_go && hit(index, `IDX_IRQ_STATUS))
                                    ? avs_writedata[1:0] : 2'h0))
                    | {done_event, auto_enable[0] & verr_rise};
    end
  end

  // pending position and delay reach the core only with a standard write
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      standard_code  <= STD_RESET[2:0];
      start_position <= `RST_START_POS;
      luma_delay     <= 6'h00;
    end else if (wr_std) begin
      standard_code  <= avs_byteenable[0] ? avs_writedata[2:0] : std_select[2:0];
      start_position <= start_pending;
      luma_delay     <= delay_pending[11:6];
    end
  end

  // reinit pulse lasts one cycle per routing write
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      standard_reinit <= 1'b0;
      irq             <= 1'b0;
    end else begin
      standard_reinit <= wr_route;
      irq             <= |(irq_status & irq_mask);
    end
  end

  // field decode kept apart from the output flops
  always @* begin
    next_auto_on     = auto_enable[0];
    next_luma_sel    = routing[1:0];
    next_chroma_sel  = routing[2];
    next_tilt        = legal_code(routing[4:3]);
    next_bandwidth   = routing[6:5];
    next_notch_fixed = routing[7];
    next_lowpass     = routing[8];
    next_speed       = legal_code(routing[10:9]);
    next_notch_shape = comb_filter_control[1:0];
    next_dot         = comb_filter_control[3:2];
    next_hdg         = comb_filter_control[5:4];
    next_vdg         = comb_filter_control[7:6];
    next_vpk         = comb_filter_control[11:8];
    next_dcr         = comb_test[2];
    next_coring      = comb_test[3];
  end

  // field outputs registered from the bank
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      auto_standard_on    <= 1'b0;
      luma_input_select   <= 2'h0;
      chroma_input_select <= 1'b0;
      tilt_compensation   <= 2'h0;
      chroma_bandwidth    <= 2'h0;
      notch_fixed         <= 1'b0;
      luma_lowpass_on     <= 1'b0;
      loop_speed          <= 2'h0;
      notch_shape         <= 2'h0;
      dot_reduction       <= 2'h0;
      horiz_diff_gain     <= 2'h0;
      vert_diff_gain      <= 2'h0;
      vert_peak_gain      <= 4'h0;
      dc_reject_on        <= 1'b0;
      coring_on           <= 1'b0;
    end else begin
      auto_standard_on    <= next_auto_on;
      luma_input_select   <= next_luma_sel;
      chroma_input_select <= next_chroma_sel;
      tilt_compensation   <= next_tilt;
      chroma_bandwidth    <= next_bandwidth;
      notch_fixed         <= next_notch_fixed;
      luma_lowpass_on     <= next_lowpass;
      loop_speed          <= next_speed;
      notch_shape         <= next_notch_shape;
      dot_reduction       <= next_dot;
      horiz_diff_gain     <= next_hdg;
      vert_diff_gain      <= next_vdg;
      vert_peak_gain      <= next_vpk;
      dc_reject_on        <= next_dcr;
      coring_on           <= next_coring;
    end
  end

endmodule

/* File: hdl/video_frontend_defines.vh */
// register offsets, field positions, reset values for the video front end
`ifndef VIDEO_FRONTEND_DEFINES_VH
`define VIDEO_FRONTEND_DEFINES_VH
`define IDX_STD_SELECT     9'h020
`define IDX_ROUTING        9'h021
`define IDX_START_POS      9'h022
`define IDX_DELAY          9'h023
`define IDX_COMB_CTRL      9'h028
`define IDX_COMB_TEST      9'h055
`define IDX_AUTO_ENABLE    9'h158
`define IDX_AUTO_STATE     9'h15e
`define IDX_IRQ_STATUS     9'h1f0
`define IDX_IRQ_MASK       9'h1f1
`define IDX_EVENT_INPUTS   9'h1f2
`define RST_STD_SELECT     12'h001
`define RST_ROUTING        12'h144
`define RST_START_POS      12'h000
`define RST_DELAY          12'h000
`define RST_COMB_CTRL      12'h0e7
`define RST_COMB_TEST      12'h000
`define RST_AUTO_ENABLE    12'h000
`define RST_IRQ_MASK       12'h000
`define ROUTE_DONE_BIT     11
`define ROUTE_WR_MASK      12'h7ff
`define DELAY_WR_MASK      12'hfc0
`define TEST_WR_MASK       12'h00c
`define STD_WIDTH          3
`define REINIT_CYCLES      4'h8
`define IRQ_VERR_BIT       0
`define IRQ_DONE_BIT       1
`endif

/* File: verification/video_frontend_control_regs_assertions.sv */
// concurrent checks on the ports of the video front end register bank
`include "video_frontend_defines.vh"
module video_frontend_control_regs_assertions (
  input logic        clk_sys,
  input logic        reset_n,
  input logic [10:0] avs_address,
  input logic        avs_read,
  input logic        avs_write,
  input logic [31:0] avs_readdata,
  input logic        avs_waitrequest,
  input logic [1:0]  avs_response,
  input logic        auto_standard_on,
  input logic [2:0]  standard_code,
  input logic        standard_reinit,
  input logic [11:0] start_position,
  input logic [5:0]  luma_delay,
  input logic [1:0]  tilt_compensation,
  input logic [1:0]  loop_speed,
  input logic [3:0]  vert_peak_gain,
  input logic        dc_reject_on,
  input logic        coring_on
);
  timeunit 1ns;
  timeprecision 1ps;
  wire [8:0] idx       = avs_address[10:2];
  wire       hit       = avs_write && !avs_waitrequest;
  wire       hit_std   = hit && idx == `IDX_STD_SELECT;
  wire       hit_route = hit && idx == `IDX_ROUTING;
  wire       hit_comb  = hit && idx == `IDX_COMB_CTRL;
  wire       hit_test  = hit && idx == `IDX_COMB_TEST;
  wire       hit_auto  = hit && idx == `IDX_AUTO_ENABLE;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  a_wait_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_upper_bits_zero: assert property (!avs_waitrequest |-> avs_readdata[31:12] == 20'h0)
    else $error("read data above bit 11 not zero");
  a_unmapped_refused: assert property (avs_read && !avs_waitrequest && idx == 9'h1ff
    |-> avs_response == 2'b10 && avs_readdata == 32'h0) else $error("unmapped read answered");
  a_reinit_after_write: assert property (hit_route |-> ##[1:2] standard_reinit)
    else $error("no reinit pulse after routing write");
  a_code_by_write: assert property ($changed(standard_code) |-> $past(hit_std) ||
    $past(hit_std, 2)) else $error("standard code moved without a write");
  a_pending_applied: assert property ($changed({start_position, luma_delay}) |->
    $past(hit_std) || $past(hit_std, 2)) else $error("position or delay applied early");
  a_route_fields: assert property ($changed({tilt_compensation, loop_speed}) |->
    $past(hit_route) || $past(hit_route, 2)) else $error("routing field moved unasked");
  a_peak_by_write: assert property ($changed(vert_peak_gain) |-> $past(hit_comb) ||
    $past(hit_comb, 2)) else $error("peaking gain moved without a write");
  a_test_by_write: assert property ($changed({dc_reject_on, coring_on}) |->
    $past(hit_test) || $past(hit_test, 2)) else $error("test bits moved without a write");
  a_auto_by_write: assert property ($changed(auto_standard_on) |-> $past(hit_auto) ||
    $past(hit_auto, 2)) else $error("auto enable moved without a write");
endmodule

/* File: verification/video_frontend_control_regs_test.sv */
// directed register bench for the video front end register bank
`include "video_frontend_defines.vh"
module video_frontend_control_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys = 1'b0, reset_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic        vertical_error = 1'b0;
  logic [10:0] avs_address = 11'h000;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic [3:0]  avs_byteenable = 4'h0, vert_peak_gain;
  logic [1:0]  avs_response, rsp, luma_input_select, tilt_compensation, chroma_bandwidth;
  logic [1:0]  loop_speed, notch_shape, dot_reduction, horiz_diff_gain, vert_diff_gain, t;
  logic [2:0]  standard_code;
  logic [11:0] start_position, d;
  logic [5:0]  luma_delay;
  logic        avs_waitrequest, auto_standard_on, standard_reinit, chroma_input_select;
  logic        notch_fixed, luma_lowpass_on, dc_reject_on, coring_on, irq;
  int          failures = 0, n_checks = 0;
  logic [8:0]  ridx [8] = '{`IDX_STD_SELECT, `IDX_ROUTING, `IDX_START_POS, `IDX_DELAY,
                            `IDX_COMB_CTRL, `IDX_COMB_TEST, `IDX_AUTO_ENABLE, `IDX_AUTO_STATE};
  logic [11:0] rval [8] = '{12'h001, 12'h144, 12'h000, 12'h000, 12'h0e7, 12'h000, 12'h000,
                            12'h000};
  video_frontend_control_regs i_dut (.*);
  always #2 clk_sys = ~clk_sys;
  task automatic print_verdict;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one access; answer taken only at the edge that sees waitrequest low
  task automatic bus(input logic wr, input logic [8:0] idx, input logic [11:0] wd);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address <= {idx, 2'b00};
    avs_writedata <= {20'h0, wd};
    avs_byteenable <= 4'h3;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (avs_waitrequest !== 1'b0) begin
      failures++;
      $display("CHECK FAILED %0t bus answer timed out", $time);
      print_verdict();
    end
    q = avs_readdata;
    rsp = avs_response;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic rd(input logic [8:0] idx, input logic [11:0] e);
    bus(1'b0, idx, 12'h000);
    chk(q, {20'h0, e});
  endtask
  initial begin
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    for (int i = 0; i < 8; i++) rd(ridx[i], rval[i]);
    chk({chroma_bandwidth, notch_shape, dot_reduction, horiz_diff_gain, vert_diff_gain,
         vert_peak_gain, standard_code, auto_standard_on}, 18'h2db02);
    bus(1'b0, 9'h1ff, 12'h000);
    chk({rsp, q[29:0]}, 32'h80000000);
    bus(1'b1, 9'h1ff, 12'hfff);
    chk(rsp, 2'b10);
    // reserved code 11 of tilt and speed reads back stored but drives zero
    for (int k = 0; k < 4; k++) begin
      d = {1'b0, k[1:0], k[0], k[0], k[1:0], k[1:0], 3'b000};
      t = (k == 3) ? 2'b00 : k[1:0];
      bus(1'b1, `IDX_ROUTING, d);
      repeat (12) @(posedge clk_sys);
      chk({tilt_compensation, chroma_bandwidth, notch_fixed, luma_lowpass_on, loop_speed},
          {t, k[1:0], k[0], k[0], t});
      rd(`IDX_ROUTING, d | 12'h800);
    end
    for (int k = 0; k < 4; k++) begin
      d = {k[1:0], k[1:0], k[1:0], k[1:0], k[1:0], k[1:0]};
      bus(1'b1, `IDX_COMB_CTRL, d);
      repeat (2) @(posedge clk_sys);
      chk({vert_peak_gain, vert_diff_gain, horiz_diff_gain, dot_reduction, notch_shape},
          d);
      rd(`IDX_COMB_CTRL, d);
    end
    for (int j = 0; j < 2; j++) begin
      d = j ? 12'hff7 : 12'h00b;
      bus(1'b1, `IDX_COMB_TEST, d);
      repeat (2) @(posedge clk_sys);
      chk({dc_reject_on, coring_on}, {d[2], d[3]});
      rd(`IDX_COMB_TEST, d & 12'h00c);
    end
    bus(1'b1, `IDX_START_POS, 12'h123);
    bus(1'b1, `IDX_DELAY, 12'hfff);
    repeat (2) @(posedge clk_sys);
    chk({start_position, luma_delay}, 18'h0);
    rd(`IDX_DELAY, 12'hfc0);
    bus(1'b1, `IDX_STD_SELECT, 12'h005);
    repeat (2) @(posedge clk_sys);
    chk({standard_code, start_position, luma_delay}, {3'h5, 12'h123, 6'h3f});
    rd(`IDX_STD_SELECT, 12'h005);
    bus(1'b1, `IDX_AUTO_ENABLE, 12'h001);
    repeat (2) @(posedge clk_sys);
    chk(auto_standard_on, 1'b1);
    vertical_error <= 1'b1;
    repeat (6) @(posedge clk_sys);
    rd(`IDX_AUTO_STATE, 12'h001);
    chk(irq, 1'b0);
    bus(1'b1, `IDX_IRQ_MASK, 12'h001);
    repeat (2) @(posedge clk_sys);
    chk(irq, 1'b1);
    vertical_error <= 1'b0;
    bus(1'b1, `IDX_IRQ_STATUS, 12'h001);
    repeat (2) @(posedge clk_sys);
    chk(irq, 1'b0);
    rd(`IDX_IRQ_STATUS, 12'h002);
    bus(1'b1, `IDX_AUTO_ENABLE, 12'h000);
    repeat (2) @(posedge clk_sys);
    chk(auto_standard_on, 1'b0);
    rd(`IDX_AUTO_STATE, 12'h000);
    print_verdict();
  end
endmodule
bind video_frontend_control_regs video_frontend_control_regs_assertions i_chk (.*);
